// >>> uart_line_modem_status_tb.sv
`define CHK(got, exp) begin \
  nTests++; \
  if ((got) !== (exp)) begin \
    failCount++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); \
  end \
end

module uart_line_modem_status_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam logic [31:0] LS = ulm_pkg::LINE_STATUS_ADDR;
  localparam logic [31:0] MS = ulm_pkg::MODEM_STATUS_ADDR;
  logic clk = 1'b0;
  logic sysRst;
  logic [31:0] addr;
  logic [7:0] wdata;
  logic wrStb;
  logic rdStb;
  logic [7:0] rdata;
  ulm_pkg::ulm_cfg_t cfg;
  logic bitTick = 1'b0;
  logic [1:0] tickCnt = 2'h0;
  logic rxIn;
  logic rxBufRead;
  logic [7:0] rxHeadChar;
  logic txStore;
  logic txMove;
  logic txShiftIdle;
  ulm_pkg::ulm_modem_in_t modemPins;
  logic [3:0] controlOut;
  logic [7:0] modemFlags;
  int failCount = 0;
  int nTests = 0;

  always #4 clk = ~clk;

  // one bit time every four clocks
  always @(posedge clk) begin
    tickCnt <= tickCnt + 2'h1;
    bitTick <= (tickCnt == 2'h3);
  end

  ulm_status_top #(.DEPTH(4), .ADDR_W(32)) DUT (
    .clk(clk), .sys_rst(sysRst), .addr(addr), .wdata(wdata),
    .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata), .cfg(cfg),
    .bitTick(bitTick), .rxIn(rxIn), .rxBufRead(rxBufRead),
    .rxHeadChar(rxHeadChar), .txStore(txStore), .txMove(txMove),
    .txShiftIdle(txShiftIdle), .modemPins(modemPins),
    .controlOut(controlOut), .modemFlags(modemFlags)
  );

  ulm_modem_model m (
    .clk(clk), .bitTick(bitTick), .pins(modemPins), .rxIn(rxIn)
  );

  // ------------------------------------------------------------
  // bus and helper tasks
  // ------------------------------------------------------------
  task automatic rd(input logic [31:0] a, output logic [7:0] d);
    @(posedge clk);
    rdStb <= 1'b1;
    addr <= a;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk(input logic [31:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    `CHK(d, exp)
  endtask

  task automatic pop;
    @(posedge clk) rxBufRead <= 1'b1;
    @(posedge clk) rxBufRead <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic sendChar(input logic [7:0] d, input logic par,
                          input logic stop);
    if (cfg.parityEn) m.send({1'b1, stop, par, d, 1'b0}, 11);
    else m.send({2'b11, stop, d, 1'b0}, 10);
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic stopTest;
    $display("checks %0d, mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic testReset;
    chk(LS, 8'h60);
    chk(MS, 8'h00);
    chk(32'h0c000007, 8'h00);
    @(posedge clk) wrStb <= 1'b1;
    addr <= LS;
    wdata <= 8'h1e;
    @(posedge clk) wrStb <= 1'b0;
    chk(LS, 8'h60);
  endtask

  task automatic testTx;
    @(posedge clk) txStore <= 1'b1;
    @(posedge clk) txStore <= 1'b0;
    chk(LS, 8'h00);
    @(posedge clk) txMove <= 1'b1;
    txShiftIdle <= 1'b0;
    @(posedge clk) txMove <= 1'b0;
    chk(LS, 8'h20);
    @(posedge clk) txShiftIdle <= 1'b1;
    chk(LS, 8'h60);
  endtask

  task automatic testRx;
    sendChar(8'ha5, 1'b0, 1'b1);
    `CHK(rxHeadChar, 8'ha5)
    chk(LS, 8'h61);
    pop;
    chk(LS, 8'h60);
    @(posedge clk) cfg.parityEn <= 1'b1;
    for (int e = 0; e < 2; e++) begin
      @(posedge clk) cfg.parityEven <= e[0];
      sendChar(8'h01, 1'b0, 1'b1);
      chk(LS, {5'h0c, e[0], 2'h1});
      chk(LS, 8'h61);
      pop;
    end
    @(posedge clk) cfg.parityEn <= 1'b0;
  endtask

  task automatic testFraming;
    sendChar(8'h55, 1'b0, 1'b0);
    chk(LS, 8'h69);
    pop;
    // start bit held for two samples after the error
    m.send({1'b1, 1'b1, 8'h3c, 2'b00}, 11);
    repeat (3) @(posedge clk);
    #1 `CHK(rxHeadChar, 8'h3c)
    chk(LS, 8'h61);
    pop;
  endtask

  task automatic testBreakFifo;
    @(posedge clk) cfg.fifoEnableBit <= 1'b1;
    sendChar(8'h11, 1'b0, 1'b1);
    m.send(12'h000, 12);
    repeat (3) @(posedge clk);
    chk(LS, 8'he1);
    pop;
    `CHK(rxHeadChar, 8'h00)
    chk(LS, 8'hf1);
    pop;
    chk(LS, 8'h60);
  endtask

  task automatic testOverrun;
    @(posedge clk) cfg.fifoEnableBit <= 1'b0;
    sendChar(8'h12, 1'b0, 1'b1);
    sendChar(8'h34, 1'b0, 1'b1);
    `CHK(rxHeadChar, 8'h34)
    chk(LS, 8'h63);
    chk(LS, 8'h61);
    pop;
    @(posedge clk) cfg.fifoEnableBit <= 1'b1;
    for (int i = 1; i <= 4; i++) sendChar(i[7:0], 1'b0, 1'b1);
    chk(LS, 8'h61);
    sendChar(8'h05, 1'b0, 1'b1);
    chk(LS, 8'h63);
    for (int i = 1; i <= 4; i++) begin
      `CHK(rxHeadChar, i[7:0])
      pop;
    end
    chk(LS, 8'h60);
  endtask

  task automatic testStick;
    @(posedge clk) begin
      cfg.parityEn <= 1'b1;
      cfg.parityStick <= 1'b1;
      cfg.parityEven <= 1'b1;
      cfg.wordLen <= 2'h2;
    end
    // seven data bits, stuck parity bit sent high
    m.send({3'b111, 1'b1, 7'h41, 1'b0}, 10);
    repeat (3) @(posedge clk);
    #1 `CHK(rxHeadChar, 8'h41)
    chk(LS, 8'he5);
    pop;
    @(posedge clk) begin
      cfg.parityEn <= 1'b0;
      cfg.parityStick <= 1'b0;
      cfg.parityEven <= 1'b0;
      cfg.wordLen <= 2'h3;
    end
  endtask

  task automatic testModem;
    logic [7:0] d1;
    logic [7:0] d2;
    for (int i = 0; i < 4; i++) begin
      m.setPins(~(4'h1 << i));
      repeat (3) @(posedge clk);
      chk(MS, {4'h1 << i, 4'h1 << i});
      chk(MS, {4'h1 << i, 4'h0});
      m.setPins(4'hf);
      repeat (3) @(posedge clk);
      chk(MS, {4'h0, 4'h1 << i});
    end
    @(posedge clk) cfg.loopback <= 1'b1;
    m.setPins(4'h0);
    @(posedge clk) controlOut <= 4'h1;
    repeat (3) @(posedge clk);
    chk(MS, 8'h22);
    @(posedge clk) controlOut <= 4'h8;
    repeat (3) @(posedge clk);
    chk(MS, 8'h8a);
    m.setPins(4'hf);
    @(posedge clk) controlOut <= 4'h0;
    cfg.loopback <= 1'b0;
    repeat (3) @(posedge clk);
    rd(MS, d1);
    // change landing on the clearing read is never lost
    for (int k = 0; k < 4; k++) begin
      fork
        begin
          repeat (k) @(posedge clk);
          m.setPins(4'he);
        end
        rd(MS, d1);
      join
      repeat (3) @(posedge clk);
      rd(MS, d2);
      `CHK(d1[0] ^ d2[0], 1'b1)
      m.setPins(4'hf);
      repeat (3) @(posedge clk);
      rd(MS, d1);
    end
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    sysRst = 1'b1;
    addr = 32'h0;
    wdata = 8'h00;
    wrStb = 1'b0;
    rdStb = 1'b0;
    cfg = '0;
    cfg.wordLen = 2'h3;
    rxBufRead = 1'b0;
    txStore = 1'b0;
    txMove = 1'b0;
    txShiftIdle = 1'b1;
    controlOut = 4'h0;
    repeat (20) @(posedge clk);
    sysRst <= 1'b0;
    testReset();
    testTx();
    testRx();
    testFraming();
    testBreakFifo();
    testOverrun();
    testStick();
    testModem();
    stopTest();
  end

  initial begin
    repeat (20000) @(posedge clk);
    failCount++;
    stopTest();
  end
endmodule

// >>> ulm_modem_model.sv
module ulm_modem_model (
  // clock and bit timing
  input wire logic clk,
  input wire logic bitTick,
  // modem and serial lines
  output ulm_pkg::ulm_modem_in_t pins,
  output logic rxIn
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // line state
  // ------------------------------------------------------------
  // all modem inputs inactive, line marking
  initial begin
    pins = 4'hf;
    rxIn = 1'b1;
  end

  // ------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------
  // one bit per tick, lsb first, back to marking afterwards
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk iff bitTick);
      rxIn <= bits[i];
    end
    @(posedge clk iff bitTick);
    rxIn <= 1'b1;
  endtask

  task automatic setPins(input logic [3:0] p);
    @(posedge clk);
    pins <= p;
  endtask
endmodule

// >>> ulm_modem_status.sv
module ulm_modem_status (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // modem side
  input wire ulm_pkg::ulm_modem_in_t pins,
  input wire logic loopback,
  input wire logic [3:0] controlOut,
  // register side
  input wire logic clearChange,
  output logic [7:0] modemFlags
);

  logic primed, next_primed;
  logic [3:0] level, change;
  logic [7:0] next_modemFlags;

  // --------------------------------------------------------------
  // levels and change flags
  // --------------------------------------------------------------
  always_comb begin
    // loopback: out2->dcd, out1->ring, dtr->dsr, rts->cts
    if (loopback)
      level = {controlOut[3], controlOut[2], controlOut[0],
               controlOut[1]}; // RULE17
    else
      level = ~pins; // RULE14
    change = primed ? (level ^ modemFlags[7:4]) : 4'h0;
    next_primed = 1'b1;
    next_modemFlags = {level,
      change | (modemFlags[3:0] & {4{!clearChange}})}; // RULE15 RULE16 RULE19
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      primed <= 1'b0;
      modemFlags <= ulm_pkg::MODEM_STATUS_RST;
    end else begin
      primed <= next_primed;
      modemFlags <= next_modemFlags;
    end
  end

  a_change_flag: assert property (@(posedge clk) disable iff (sys_rst) // RULE15
    primed && !loopback && $changed(pins) && $stable(loopback) |=>
      (modemFlags[3:0] & ($past(pins) ^ $past(pins, 2))) != 4'h0)
    else $error("modem input change not flagged");
  a_read_clears: assert property (@(posedge clk) disable iff (sys_rst) // RULE16
    clearChange && change == 4'h0 |=> modemFlags[3:0] == 4'h0)
    else $error("modem change flags not cleared on read");
  c_modem_change: cover property (@(posedge clk) disable iff (sys_rst)
    change != 4'h0);

endmodule

// >>> ulm_pkg.sv
package ulm_pkg;

  // --------------------------------------------------------------
  // register map
  // --------------------------------------------------------------
  localparam logic [31:0] LINE_STATUS_ADDR = 32'h0c000005;
  localparam logic [31:0] MODEM_STATUS_ADDR = 32'h0c000006;
  localparam logic [7:0] LINE_STATUS_RST = 8'h60;
  localparam logic [7:0] MODEM_STATUS_RST = 8'h00;

  // --------------------------------------------------------------
  // line status field positions
  // --------------------------------------------------------------
  localparam int LS_READY = 0;
  localparam int LS_OVERRUN = 1;
  localparam int LS_PARITY = 2;
  localparam int LS_FRAMING = 3;
  localparam int LS_BREAK = 4;
  localparam int LS_HOLD_EMPTY = 5;
  localparam int LS_TX_EMPTY = 6;
  localparam int LS_ERR_SUM = 7;

  // --------------------------------------------------------------
  // shared types
  // --------------------------------------------------------------
  typedef struct packed {
    logic fifoEnableBit;
    logic loopback;
    logic parityEn;
    logic parityEven;
    logic parityStick;
    logic [1:0] wordLen;
  } ulm_cfg_t;

  typedef struct packed {
    logic carrierDetectN;
    logic phoneRingingN;
    logic dataSetReadyN;
    logic clearToSendN;
  } ulm_modem_in_t;

  typedef struct packed {
    logic brk;
    logic fe;
    logic pe;
  } ulm_rx_err_t;

endpackage

// >>> ulm_rx_frame.sv
module ulm_rx_frame (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // serial side
  input wire logic bitTick,
  input wire logic rxIn,
  input wire ulm_pkg::ulm_cfg_t cfg,
  // received character
  output logic charValid,
  output logic [7:0] charData,
  output ulm_pkg::ulm_rx_err_t charErr
);

  typedef enum logic [2:0] {
    IDLE, DATA, PARITY, STOP, BRKCHK, MARKWAIT, RESYNC
  } ulm_rx_state_t;

  ulm_rx_state_t state, next_state;
  logic [7:0] shiftReg, next_shiftReg;
  logic [2:0] bitCnt, next_bitCnt;
  logic parBit, next_parBit;
  logic seenLow, next_seenLow;
  logic next_charValid;
  logic [7:0] next_charData;
  ulm_pkg::ulm_rx_err_t next_charErr;
  logic [7:0] aligned;
  logic parFail;

  // --------------------------------------------------------------
  // framing, parity and break detection
  // --------------------------------------------------------------
  always_comb begin
    aligned = shiftReg >> (3'd3 - cfg.wordLen);
    if (!cfg.parityEn)
      parFail = 1'b0;
    else if (cfg.parityStick)
      parFail = (parBit == cfg.parityEven);
    else
      parFail = (^aligned ^ parBit) == cfg.parityEven; // RULE10
  end

  always_comb begin
    next_state = state;
    next_shiftReg = shiftReg;
    next_bitCnt = bitCnt;
    next_parBit = parBit;
    next_seenLow = seenLow;
    next_charValid = 1'b0;
    next_charData = charData;
    next_charErr = charErr;
    if (bitTick) begin
      unique case (state)
        IDLE: begin
          if (!rxIn) begin
            next_state = DATA;
            next_bitCnt = 3'h0;
            next_parBit = 1'b0;
          end
        end
        DATA: begin
          next_shiftReg = {rxIn, shiftReg[7:1]};
          next_bitCnt = bitCnt + 3'h1;
          if (bitCnt == {1'b1, cfg.wordLen})
            next_state = cfg.parityEn ? PARITY : STOP;
        end
        PARITY: begin
          next_parBit = rxIn;
          next_state = STOP;
        end
        STOP: begin
          next_charData = aligned;
          next_charErr = '{brk: 1'b0, fe: !rxIn, pe: parFail};
          if (rxIn) begin
            next_charValid = 1'b1;
            next_state = IDLE;
          end else if (aligned == 8'h00 && !parBit) begin
            next_state = BRKCHK;
          end else begin
            next_charValid = 1'b1; // RULE8
            next_state = RESYNC;
            next_seenLow = 1'b0;
          end
        end
        BRKCHK: begin
          next_charValid = 1'b1;
          if (!rxIn) begin
            next_charData = 8'h00; // RULE7
            next_charErr = '{brk: 1'b1, fe: 1'b0, pe: 1'b0}; // RULE4
            next_state = MARKWAIT;
          end else begin
            next_state = IDLE;
          end
        end
        MARKWAIT: begin
          if (rxIn)
            next_state = IDLE; // RULE7
        end
        RESYNC: begin
          next_seenLow = !rxIn;
          if (!rxIn && seenLow) begin
            next_state = DATA; // RULE9
            next_bitCnt = 3'h0;
            next_parBit = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= IDLE;
      shiftReg <= 8'h00;
      bitCnt <= 3'h0;
      parBit <= 1'b0;
      seenLow <= 1'b0;
      charValid <= 1'b0;
      charData <= 8'h00;
      charErr <= '0;
    end else begin
      state <= next_state;
      shiftReg <= next_shiftReg;
      bitCnt <= next_bitCnt;
      parBit <= next_parBit;
      seenLow <= next_seenLow;
      charValid <= next_charValid;
      charData <= next_charData;
      charErr <= next_charErr;
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  a_break_zero: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
    state == BRKCHK && bitTick && !rxIn |=>
      charValid && charErr.brk && charData == 8'h00 && state == MARKWAIT)
    else $error("break did not load one zero character");
  a_stop_framing: assert property (@(posedge clk) disable iff (sys_rst) // RULE8
    state == STOP && bitTick && !rxIn && aligned != 8'h00 |=>
      charValid && charErr.fe)
    else $error("low stop bit not flagged as framing error");
  a_resync_twice: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
    state == RESYNC && bitTick && !seenLow |=> state != DATA)
    else $error("data accepted after one start sample");
  c_break_seen: cover property (@(posedge clk) disable iff (sys_rst)
    charValid && charErr.brk);

endmodule

// >>> ulm_status_top.sv
// Summary of operation
// RULE1 - error summary only in fifo mode
// RULE2 - tx empty needs holding and shift idle
// RULE3 - holding empty set on move, cleared on store
// RULE4 - break after low beyond one character
// RULE5 - line status read clears error flags
// RULE6 - fifo errors reported at queue head
// RULE7 - break loads one zero character, waits mark
// RULE8 - low stop sample is framing error
// RULE9 - resync needs start sampled twice
// RULE10 - parity checked against configured sense
// RULE11 - non-fifo overwrite sets overrun
// RULE12 - full fifo drops new character, overrun
// RULE13 - data ready while buffer holds data
// RULE14 - upper modem bits show inverted inputs
// RULE15 - lower modem bits flag input changes
// RULE16 - modem status read clears change flags
// RULE17 - loopback feeds control outputs back
// RULE18 - fifo mode follows fifo enable bit
// RULE19 - new event beats clearing read
module ulm_status_top #(
  parameter int DEPTH = 16,
  parameter int ADDR_W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [7:0] rdata,
  // line configuration and serial input
  input wire ulm_pkg::ulm_cfg_t cfg,
  input wire logic bitTick,
  input wire logic rxIn,
  // receive buffer unload
  input wire logic rxBufRead,
  output logic [7:0] rxHeadChar,
  // transmit side state
  input wire logic txStore,
  input wire logic txMove,
  input wire logic txShiftIdle,
  // modem side
  input wire ulm_pkg::ulm_modem_in_t modemPins,
  input wire logic [3:0] controlOut,
  output logic [7:0] modemFlags
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic charValid;
  logic [7:0] charData;
  ulm_pkg::ulm_rx_err_t charErr;

  logic [10:0] mem [DEPTH];
  logic [PW-1:0] wrPtr, next_wrPtr, rdPtr, next_rdPtr, memIdx, headNext;
  logic [CW-1:0] count, next_count, errEntries, next_errEntries;
  logic memWe, pop, fifoMode, arrive, overrun, lsRead, msRead;
  ulm_pkg::ulm_rx_err_t arriveErr;
  logic brk, fe, pe, oe, thre, temt;
  logic next_brk, next_fe, next_pe, next_oe, next_thre, next_temt;
  logic [7:0] lineFlags, next_rdata, next_rxHeadChar;

  // --------------------------------------------------------------
  // receive framing and modem status
  // --------------------------------------------------------------
  ulm_rx_frame u_rx (
    .clk(clk),
    .sys_rst(sys_rst),
    .bitTick(bitTick),
    .rxIn(rxIn),
    .cfg(cfg),
    .charValid(charValid),
    .charData(charData),
    .charErr(charErr)
  );

  ulm_modem_status u_modem (
    .clk(clk),
    .sys_rst(sys_rst),
    .pins(modemPins),
    .loopback(cfg.loopback),
    .controlOut(controlOut),
    .clearChange(msRead),
    .modemFlags(modemFlags)
  );

  // --------------------------------------------------------------
  // receive buffer
  // --------------------------------------------------------------
  always_comb begin
    fifoMode = cfg.fifoEnableBit; // RULE18
    lsRead = rdStb && addr == ADDR_W'(ulm_pkg::LINE_STATUS_ADDR);
    msRead = rdStb && addr == ADDR_W'(ulm_pkg::MODEM_STATUS_ADDR);
    pop = rxBufRead && count != '0;
    headNext = rdPtr + PW'(1);
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    next_count = count;
    next_errEntries = errEntries;
    memWe = 1'b0;
    memIdx = wrPtr;
    arrive = 1'b0;
    arriveErr = charErr;
    overrun = 1'b0;
    if (!fifoMode) begin
      next_errEntries = '0;
      if (charValid) begin
        memWe = 1'b1;
        memIdx = rdPtr;
        arrive = 1'b1;
        overrun = count != '0 && !pop; // RULE11
        next_count = CW'(1);
      end else if (pop) begin
        next_count = '0;
      end
    end else begin
      if (pop) begin
        next_rdPtr = headNext;
        if (mem[rdPtr][10:8] != 3'h0)
          next_errEntries = next_errEntries - CW'(1);
        if (count > CW'(1)) begin
          arrive = 1'b1; // RULE6
          arriveErr = ulm_pkg::ulm_rx_err_t'(mem[headNext][10:8]);
        end else if (charValid) begin
          arrive = 1'b1;
        end
      end
      if (charValid) begin
        if (count == FULL && !pop) begin
          overrun = 1'b1; // RULE12
        end else begin
          memWe = 1'b1;
          next_wrPtr = wrPtr + PW'(1);
          next_count = next_count + CW'(1);
          if (charErr != '0)
            next_errEntries = next_errEntries + CW'(1);
          if (count == '0)
            arrive = 1'b1;
        end
      end
      if (pop)
        next_count = next_count - CW'(1);
    end
  end

  // --------------------------------------------------------------
  // line status flags
  // --------------------------------------------------------------
  always_comb begin
    next_brk = (arrive && arriveErr.brk) || (brk && !lsRead); // RULE5 RULE19
    next_fe = (arrive && arriveErr.fe) || (fe && !lsRead); // RULE5 RULE19
    next_pe = (arrive && arriveErr.pe) || (pe && !lsRead); // RULE5 RULE19
    next_oe = overrun || (oe && !lsRead); // RULE5 RULE19
    next_thre = txMove || (thre && !txStore); // RULE3
    next_temt = next_thre && txShiftIdle; // RULE2
    lineFlags = {fifoMode && errEntries != '0, temt, thre, brk, fe, pe,
                 oe, count != '0}; // RULE1 RULE13
    next_rdata = 8'h00;
    if (lsRead)
      next_rdata = lineFlags;
    else if (msRead)
      next_rdata = modemFlags;
    next_rxHeadChar = mem[rdPtr][7:0];
  end

  always_ff @(posedge clk) begin
    if (memWe)
      mem[memIdx] <= {charErr, charData};
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      errEntries <= '0;
      brk <= ulm_pkg::LINE_STATUS_RST[ulm_pkg::LS_BREAK];
      fe <= ulm_pkg::LINE_STATUS_RST[ulm_pkg::LS_FRAMING];
      pe <= ulm_pkg::LINE_STATUS_RST[ulm_pkg::LS_PARITY];
      oe <= ulm_pkg::LINE_STATUS_RST[ulm_pkg::LS_OVERRUN];
      thre <= ulm_pkg::LINE_STATUS_RST[ulm_pkg::LS_HOLD_EMPTY];
      temt <= ulm_pkg::LINE_STATUS_RST[ulm_pkg::LS_TX_EMPTY];
      rdata <= 8'h00;
      rxHeadChar <= 8'h00;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
      errEntries <= next_errEntries;
      brk <= next_brk;
      fe <= next_fe;
      pe <= next_pe;
      oe <= next_oe;
      thre <= next_thre;
      temt <= next_temt;
      rdata <= next_rdata;
      rxHeadChar <= next_rxHeadChar;
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  a_sum_nonfifo: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
    lsRead && !fifoMode |=> rdata[ulm_pkg::LS_ERR_SUM] == 1'b0)
    else $error("error summary set outside fifo mode");
  a_temt_gate: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
    !txShiftIdle || txStore && !txMove |=> !temt)
    else $error("tx empty while data still held");
  a_thre_move: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
    txMove |=> thre ##1 (thre || $past(txStore)))
    else $error("holding empty not set by move");
  a_read_clear: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
    lsRead && !arrive && !overrun |=> {brk, fe, pe, oe} == 4'h0)
    else $error("error flags not cleared by status read");
  a_set_wins: assert property (@(posedge clk) disable iff (sys_rst) // RULE19
    lsRead && overrun |=> oe ##1 (oe || $past(lsRead)))
    else $error("overrun lost on clearing read");
  a_head_only: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
    fifoMode && charValid && charErr.pe && count != '0 && !pop && !pe
      |=> !pe)
    else $error("parity reported before reaching head");
  a_overrun_buf: assert property (@(posedge clk) disable iff (sys_rst) // RULE11
    !fifoMode && charValid && count != '0 && !pop |=>
      oe && count == CW'(1) && mem[rdPtr][7:0] == $past(charData))
    else $error("unread character not overwritten with overrun");
  a_full_drop: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
    fifoMode && charValid && count == FULL && !pop |=>
      oe && count == FULL && wrPtr == $past(wrPtr))
    else $error("full fifo accepted character or no overrun");
  a_ready_bit: assert property (@(posedge clk) disable iff (sys_rst) // RULE13
    lsRead |=> rdata[ulm_pkg::LS_READY] == $past(count != '0))
    else $error("data ready does not follow buffer");
  c_overrun: cover property (@(posedge clk) disable iff (sys_rst)
    overrun && fifoMode);
  c_fifo_full: cover property (@(posedge clk) disable iff (sys_rst)
    count == FULL);
  c_set_clear: cover property (@(posedge clk) disable iff (sys_rst)
    lsRead && arrive && arriveErr != '0);

endmodule
